// *** hw/adc_fifo_params.svh ***
// Offsets, field positions, reset values and lengths for the sample queue block
`ifndef ADC_FIFO_PARAMS_SVH
`define ADC_FIFO_PARAMS_SVH
`define QUEUE_CTRL_OFFSET   8'h3a
`define STATUS_FLAGS_OFFSET 8'h3b
`define QUEUE_DATA_OFFSET   8'h3d
`define CMD_READ_BIT        8'h40
`define CTRL_RESET          24'h040200
`define STATUS_RESET        8'h01
`define QUEUE_DEPTH         9'h100
`define CRC_POLY            16'ha2eb
`define CRC_INIT            16'hffff
`define CTL_MODE_LO         16
`define CTL_TAG_BIT         18
`define CTL_STAT_BIT        19
`define CTL_IEN_LO          8
`define ST_EMPTY            0
`define ST_WM               1
`define ST_OVR              2
`define ST_LOW              3
`define ST_HIGH             4
`define ST_RDERR            5
`define ST_WRERR            6
`define TAG_HIT             6
`define TAG_WM              5
`define TAG_DRAINED         4
`define CMD_LAST_BIT        6'h07
`define HDR_LAST_BIT        6'h0f
`define CTRL_LAST_BIT       6'h1f
`define BIT_COUNT_MAX       6'h20
`define LEN_TAGGED          5'h18
`define LEN_PLAIN           5'h10
`endif

// *** hw/adc_fifo_pkg.sv ***
// Types shared by the sample queue block
package adc_fifo_pkg;
	typedef enum logic [1:0] {
		MODE_OFF       = 2'b00,
		MODE_WATERMARK = 2'b01,
		MODE_STREAM    = 2'b10,
		MODE_SPARE     = 2'b11
	} fifo_mode_t;
	typedef enum logic [1:0] {
		UNIT_HDR    = 2'b00,
		UNIT_SAMPLE = 2'b01,
		UNIT_CRC    = 2'b10,
		UNIT_IDLE   = 2'b11
	} out_unit_t;
endpackage : adc_fifo_pkg

// *** hw/adc_fifo_status.sv ***
// Conversion result queue with status flags, sample tags, readback CRC and interrupt
`timescale 1ns/1ps
`include "adc_fifo_params.svh"
// What this block does
// (RQ1) Data-out shows busy while core writes
// (RQ2) Watermark mode: busy until count reaches watermark
// (RQ3) Streaming mode: busy pulse after each stored conversion
// (RQ4) Tag: hit, watermark, drained, source index
// (RQ5) Tag stored unless tag append cleared
// (RQ6) Final sample's tag carries drained bit
// (RQ7) Watermark flag while count at/above watermark
// (RQ8) Per-sample hit bit, enabled input, out of range
// (RQ9) Status byte sent during sample-count byte
// (RQ10) Drained flag on last read, cleared by write
// (RQ11) Overrun flag on lost result, cleared when emptied
// (RQ12) Limit flags sticky until readout or clear
// (RQ13) Read during write: error, zero data
// (RQ14) Postpone one write, else write error
// (RQ15) Status bit 7 mirrors main error bit
// (RQ16) CRC only with CRC on, tag on, status off
// (RQ17) CRC after each watermark-sized sample group
// (RQ18) First CRC covers command and count bytes
// (RQ19) CRC polynomial fixed, seeded all ones
// (RQ20) Interrupt is OR of enabled sources
// (RQ21) Watermark interrupt on by default, zero means 256
// (RQ22) Read command then count byte, zero means 256
// (RQ23) Control write empties queue and flags only if mode was not off before the write
// (RQ24) Occupancy counter spans zero to 256
module adc_fifo_status
	import adc_fifo_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sclk,
	input  wire logic        csN,
	input  wire logic        sdi,
	output logic             sdo,
	input  wire logic        convValid,
	input  wire logic [15:0] convData,
	input  wire logic [3:0]  sourceIndex,
	input  wire logic [15:0] perInputLimitCheckEnable,
	input  wire logic [11:0] upperLimitValue,
	input  wire logic [11:0] lowerLimitValue,
	input  wire logic        crcEnable,
	input  wire logic        mainError,
	output logic             fifoIrq
);
	localparam logic [7:0] FIFO_READ_CMD = `CMD_READ_BIT | `QUEUE_DATA_OFFSET;
	localparam logic [7:0] STAT_READ_CMD = `CMD_READ_BIT | `STATUS_FLAGS_OFFSET;
	localparam logic [7:0] CTRL_WRITE_CMD = `QUEUE_CTRL_OFFSET;
	localparam logic [7:0] STATUS_RV = `STATUS_RESET;

	function automatic logic [8:0] wm_depth(input logic [7:0] wm);
		wm_depth = (wm == 8'h00) ? `QUEUE_DEPTH : {1'b0, wm}; // RQ21
	endfunction : wm_depth

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CRC_POLY : 16'h0000); // RQ19
	endfunction : crc_step

	logic [23:0] mem [0:255];

	// Core clock domain state
	logic        csS1_q, csS2_q, csS3_q;
	logic        tglS1_q, tglS2_q, tglS3_q;
	logic [23:0] ctrl_q;
	logic [8:0]  count_q, count_d;
	logic [7:0]  rdPtr_q, rdPtr_d;
	logic        pend_q, pend_d;
	logic [19:0] pendWord_q, pendWord_d;
	logic        wrBusy_q, grant_q, readyInd_q;
	logic [6:0]  stat_q, stat_d;

	// Link domain state
	logic [5:0]  bitCnt_q;
	logic [23:0] inSr_q, outSr_q, outSr_d;
	logic [7:0]  cmd_q, num_q;
	logic [4:0]  left_q, left_d;
	logic        sdoBit_q, sdoBit_d;
	logic [15:0] crc_q, crc_d;
	logic [8:0]  grp_q, grp_d;
	out_unit_t   unit_q, unit_d;
	logic [8:0]  sampIdx_q;
	logic        readEmpty_q, isRd_q, ctrlTgl_q;
	logic [23:0] ctrlWord_q;
	logic [50:0] syncA_q, syncB_q;

	// Core domain decoding
	wire fifo_mode_t mode = fifo_mode_t'(ctrl_q[`CTL_MODE_LO+1:`CTL_MODE_LO]);
	wire        enabled = (mode != MODE_OFF);
	wire [8:0]  wmDepth = wm_depth(ctrl_q[7:0]);
	wire        active = !csS2_q || !csS3_q;
	wire        frameStart = !csS2_q && csS3_q;
	wire        frameEnd = csS2_q && !csS3_q;
	wire        ctrlEvt = tglS2_q ^ tglS3_q;
	wire        clearEvt = ctrlEvt && enabled; // RQ23
	wire        rdEnd = frameEnd && isRd_q;
	wire [8:0]  consumed = (sampIdx_q >= count_q) ? count_q : sampIdx_q;
	wire        emptiedByRead = rdEnd && grant_q && (sampIdx_q >= count_q);
	wire        readEmptyHit = rdEnd && grant_q && readEmpty_q;
	wire        wmLevel = (count_q >= wmDepth); // RQ7
	wire        wrWant = enabled && (convValid || pend_q) && !clearEvt;
	wire        wmBlocked = (mode == MODE_WATERMARK) && wmLevel;
	wire        wrAttempt = wrWant && !active;
	wire        doStore = wrAttempt && !wmBlocked;
	wire        fullDrop = doStore && (count_q == `QUEUE_DEPTH);
	wire        holdLoss = active && enabled && convValid && pend_q && !clearEvt;
	wire [19:0] wrRaw = pend_q ? pendWord_q : {convData, sourceIndex};
	wire [3:0]  wrSrc = wrRaw[3:0];
	wire        limEn = perInputLimitCheckEnable[wrSrc];
	wire        hiHit = limEn && (wrRaw[19:8] > upperLimitValue); // RQ8
	wire        loHit = limEn && (wrRaw[19:8] < lowerLimitValue); // RQ8
	wire        wmAfter = (fullDrop ? count_q : count_q + 9'h001) >= wmDepth;
	wire [7:0]  wrTag = {1'b0, hiHit || loHit, wmAfter, 1'b0, wrSrc}; // RQ4
	wire [7:0]  wrAddr = rdPtr_q + count_q[7:0];
	wire [7:0]  statusByte = {mainError, stat_q[6:2], wmLevel, stat_q[0]}; // RQ15
	wire        irqSrc = |(statusByte[6:0] & ctrl_q[`CTL_IEN_LO+6:`CTL_IEN_LO]); // RQ20
	wire        readyInd_d = enabled && ((mode == MODE_WATERMARK) ?
		(!wmLevel || wrBusy_q) : wrBusy_q);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			{csS1_q, csS2_q, csS3_q} <= 3'b111;
			{tglS1_q, tglS2_q, tglS3_q} <= 3'b000;
			ctrl_q <= `CTRL_RESET;
			count_q <= 9'h000;
			rdPtr_q <= 8'h00;
			pend_q <= 1'b0;
			pendWord_q <= 20'h00000;
			wrBusy_q <= 1'b0;
			grant_q <= 1'b0;
			readyInd_q <= 1'b0;
			stat_q <= STATUS_RV[6:0];
			fifoIrq <= 1'b0;
		end
		else
		begin
			{csS1_q, csS2_q, csS3_q} <= {csN, csS1_q, csS2_q};
			{tglS1_q, tglS2_q, tglS3_q} <= {ctrlTgl_q, tglS1_q, tglS2_q};
			if (ctrlEvt)
				ctrl_q <= ctrlWord_q;
			count_q <= count_d;
			rdPtr_q <= rdPtr_d;
			pend_q <= pend_d;
			pendWord_q <= pendWord_d;
			wrBusy_q <= doStore;
			grant_q <= frameStart ? !wrBusy_q : (frameEnd ? 1'b0 : grant_q); // RQ13
			readyInd_q <= readyInd_d; // RQ1 RQ2 RQ3
			stat_q <= stat_d;
			fifoIrq <= irqSrc; // RQ20
		end
	end

	always_ff @(posedge clk)
	begin
		if (doStore)
			mem[wrAddr] <= {wrRaw[19:4], ctrl_q[`CTL_TAG_BIT] ? wrTag : 8'h00}; // RQ5
	end

	always_comb
	begin
		count_d = count_q;
		rdPtr_d = rdPtr_q;
		pend_d = pend_q;
		pendWord_d = pendWord_q;
		if (clearEvt)
		begin
			count_d = 9'h000;
			rdPtr_d = 8'h00;
			pend_d = 1'b0;
		end
		else if (rdEnd && grant_q)
		begin
			count_d = count_q - consumed; // RQ24
			rdPtr_d = rdPtr_q + consumed[7:0];
		end
		else if (doStore)
		begin
			if (fullDrop)
				rdPtr_d = rdPtr_q + 8'h01; // RQ11
			else
				count_d = count_q + 9'h001; // RQ24
		end
		if (!clearEvt)
		begin
			if (active && enabled && convValid && !pend_q)
			begin
				pend_d = 1'b1; // RQ14
				pendWord_d = {convData, sourceIndex};
			end
			else if (wrAttempt && pend_q)
			begin
				pend_d = convValid;
				pendWord_d = {convData, sourceIndex};
			end
		end
	end

	always_comb
	begin
		stat_d = stat_q;
		if (doStore)
			stat_d[`ST_EMPTY] = 1'b0;
		if (readEmptyHit || emptiedByRead || clearEvt)
			stat_d[`ST_EMPTY] = 1'b1; // RQ10
		if (emptiedByRead || clearEvt)
			stat_d[`ST_OVR] = 1'b0;
		if (fullDrop || (wrAttempt && wmBlocked))
			stat_d[`ST_OVR] = 1'b1; // RQ11
		if (emptiedByRead || clearEvt)
		begin
			stat_d[`ST_LOW] = 1'b0;
			stat_d[`ST_HIGH] = 1'b0;
		end
		if (doStore && loHit)
			stat_d[`ST_LOW] = 1'b1; // RQ12
		if (doStore && hiHit)
			stat_d[`ST_HIGH] = 1'b1; // RQ12
		if ((rdEnd && grant_q) || emptiedByRead || clearEvt)
			stat_d[`ST_RDERR] = 1'b0;
		if (rdEnd && !grant_q)
			stat_d[`ST_RDERR] = 1'b1; // RQ13
		if (emptiedByRead || clearEvt)
			stat_d[`ST_WRERR] = 1'b0;
		if (holdLoss || (wrAttempt && wmBlocked))
			stat_d[`ST_WRERR] = 1'b1; // RQ14
		stat_d[`ST_WM] = 1'b0;
	end

	// Link side: count, read pointer and control from the core domain are static while a granted frame runs
	wire [50:0] bundle = {crcEnable, grant_q, statusByte, count_q, rdPtr_q, ctrl_q};
	wire        sCrcEn = syncB_q[50];
	wire        sGrant = syncB_q[49];
	wire [7:0]  sStatus = syncB_q[48:41];
	wire [8:0]  sCount = syncB_q[40:32];
	wire [7:0]  sRdPtr = syncB_q[31:24];
	wire [23:0] sCtrl = syncB_q[23:0];
	wire        sTagOn = sCtrl[`CTL_TAG_BIT];
	wire        sStatOn = sCtrl[`CTL_STAT_BIT];
	wire        frameRst = rst || csN;
	wire [7:0]  cmdNow = {inSr_q[6:0], sdi};
	wire        fifoRdCmd = (cmd_q == FIFO_READ_CMD);
	wire        statusOut = (cmdNow == STAT_READ_CMD) || ((cmdNow == FIFO_READ_CMD) && sStatOn);
	wire        dataPhase = fifoRdCmd && (bitCnt_q >= `HDR_LAST_BIT);
	wire [8:0]  numEff = (num_q == 8'h00) ? `QUEUE_DEPTH : {1'b0, num_q}; // RQ22
	wire        crcOn = sCrcEn && !sStatOn && sTagOn; // RQ16
	wire        crcDue = crcOn && (grp_q == wm_depth(sCtrl[7:0])); // RQ17
	wire        sampValid = sGrant && (sampIdx_q < sCount);
	wire        drainedTag = sGrant && ((sampIdx_q + 9'h001) >= sCount); // RQ6
	wire [23:0] memWord = mem[sRdPtr + sampIdx_q[7:0]];
	wire [7:0]  tagOut = (sampValid ? memWord[7:0] : 8'h00) | {3'b000, drainedTag, 4'h0};
	wire [23:0] sampWord = {sampValid ? memWord[23:8] : 16'h0000, sTagOn ? tagOut : 8'h00};
	wire [4:0]  sampLen = sTagOn ? `LEN_TAGGED : `LEN_PLAIN;
	wire [15:0] crcIn = (bitCnt_q <= `HDR_LAST_BIT) ? crc_step(crc_q, sdi) : crc_q; // RQ18
	wire        takeSample = dataPhase && (left_q == 5'h00) && !crcDue && (sampIdx_q < numEff);

	always_comb
	begin
		outSr_d = {outSr_q[22:0], 1'b0};
		left_d = (left_q != 5'h00) ? left_q - 5'h01 : 5'h00;
		sdoBit_d = outSr_q[23];
		unit_d = unit_q;
		grp_d = grp_q;
		crc_d = crcIn;
		if ((bitCnt_q == `CMD_LAST_BIT) && statusOut)
		begin
			sdoBit_d = sStatus[7]; // RQ9
			outSr_d = {sStatus[6:0], 17'h00000};
			left_d = 5'h07;
			unit_d = UNIT_HDR;
		end
		else if (dataPhase && (left_q == 5'h00))
		begin
			if (crcDue)
			begin
				sdoBit_d = crcIn[15]; // RQ17
				outSr_d = {crcIn[14:0], 9'h000};
				left_d = 5'h0f;
				unit_d = UNIT_CRC;
				grp_d = 9'h000;
				crc_d = `CRC_INIT; // RQ18
			end
			else if (takeSample)
			begin
				sdoBit_d = sampWord[23];
				outSr_d = {sampWord[22:0], 1'b0};
				left_d = sampLen - 5'h01;
				unit_d = UNIT_SAMPLE;
				grp_d = grp_q + 9'h001;
				crc_d = crc_step(crcIn, sampWord[23]);
			end
			else
			begin
				sdoBit_d = 1'b0;
				unit_d = UNIT_IDLE;
			end
		end
		else if (dataPhase)
		begin
			case (unit_q)
				UNIT_SAMPLE: crc_d = crc_step(crcIn, outSr_q[23]);
				UNIT_HDR, UNIT_CRC, UNIT_IDLE: crc_d = crcIn;
				default: crc_d = crcIn;
			endcase
		end
	end

	always_ff @(posedge sclk or posedge frameRst)
	begin
		if (frameRst)
		begin
			bitCnt_q <= 6'h00;
			inSr_q <= 24'h000000;
			cmd_q <= 8'h00;
			num_q <= 8'h00;
			outSr_q <= 24'h000000;
			left_q <= 5'h00;
			sdoBit_q <= 1'b0;
			crc_q <= `CRC_INIT; // RQ19
			grp_q <= 9'h000;
			unit_q <= UNIT_IDLE;
		end
		else
		begin
			bitCnt_q <= (bitCnt_q == `BIT_COUNT_MAX) ? bitCnt_q : bitCnt_q + 6'h01;
			inSr_q <= {inSr_q[22:0], sdi};
			if (bitCnt_q == `CMD_LAST_BIT)
				cmd_q <= cmdNow;
			if (bitCnt_q == `HDR_LAST_BIT)
				num_q <= cmdNow; // RQ22
			outSr_q <= outSr_d;
			left_q <= left_d;
			sdoBit_q <= sdoBit_d;
			crc_q <= crc_d;
			grp_q <= grp_d;
			unit_q <= unit_d;
		end
	end

	always_ff @(posedge sclk or posedge rst)
	begin
		if (rst)
		begin
			sampIdx_q <= 9'h000;
			readEmpty_q <= 1'b0;
			isRd_q <= 1'b0;
			ctrlTgl_q <= 1'b0;
			ctrlWord_q <= `CTRL_RESET;
			syncA_q <= 51'h0;
			syncB_q <= 51'h0;
		end
		else
		begin
			syncA_q <= bundle;
			syncB_q <= syncA_q;
			if (bitCnt_q == 6'h00)
			begin
				sampIdx_q <= 9'h000;
				readEmpty_q <= 1'b0;
				isRd_q <= 1'b0;
			end
			else if (bitCnt_q == `CMD_LAST_BIT)
				isRd_q <= (cmdNow == FIFO_READ_CMD);
			else if (takeSample)
			begin
				sampIdx_q <= sampIdx_q + 9'h001;
				readEmpty_q <= readEmpty_q || (sampIdx_q >= sCount); // RQ10
			end
			if ((bitCnt_q == `CTRL_LAST_BIT) && (cmd_q == CTRL_WRITE_CMD))
			begin
				ctrlWord_q <= {inSr_q[22:0], sdi}; // RQ23
				ctrlTgl_q <= !ctrlTgl_q;
			end
		end
	end

	assign sdo = csN ? readyInd_q : sdoBit_q; // RQ1

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_irq_or_form: assert property (##1 fifoIrq == $past(irqSrc)) // RQ20
		else $error("interrupt differs from OR of enabled sources");
	chk_wm_flag_level: assert property ((wmLevel && !clearEvt && !rdEnd) |=> statusByte[`ST_WM]) // RQ7
		else $error("watermark flag low at watermark");
	chk_wm_ready_low: assert property ((mode == MODE_WATERMARK && wmLevel && !wrBusy_q) |=> !sdo || !csN) // RQ2
		else $error("ready still high at watermark");
	chk_drain_clear: assert property (doStore |=> !statusByte[`ST_EMPTY]) // RQ10
		else $error("drained flag survives a write");
	chk_stream_overrun: assert property ((fullDrop && mode == MODE_STREAM) |=> stat_q[`ST_OVR] && count_q == `QUEUE_DEPTH) // RQ11
		else $error("streaming overrun missed");
	chk_limit_sticky: assert property ((stat_q[`ST_HIGH] && !clearEvt && !emptiedByRead) |=> stat_q[`ST_HIGH]) // RQ12
		else $error("upper limit flag dropped");
	chk_write_hold: assert property (holdLoss |=> stat_q[`ST_WRERR]) // RQ14
		else $error("write error not raised");
	chk_read_collide: assert property ((rdEnd && !grant_q) |=> stat_q[`ST_RDERR] ##1 stat_q[`ST_RDERR]) // RQ13
		else $error("read collision not flagged");
	chk_count_range: assert property (count_q <= `QUEUE_DEPTH) // RQ24
		else $error("occupancy out of range");

	cov_wm_reach: cover property (!wmLevel ##1 wmLevel);
	cov_stream_drop: cover property (fullDrop);
	cov_granted_read: cover property (rdEnd && grant_q && sampIdx_q != 9'h000);
	cov_write_err: cover property (holdLoss);
endmodule : adc_fifo_status

// *** verif/host_spi_model.sv ***
// Host side of the serial link: framing, serial clock and bit capture
`timescale 1ns/1ps
module host_spi_model (
	output logic      sclk,
	output logic      csN,
	output logic      sdi,
	input  wire logic sdo
);
	initial
	begin
		sclk = 1'b0;
		csN  = 1'b1;
		sdi  = 1'b1;
	end
	// Clock runs only inside a frame; released data line shows the inverse of its last bit
	task automatic xfer(input logic [31:0] tx, input int n, output logic [95:0] rx);
		rx  = '0;
		csN = 1'b0;
		#5;
		for (int k = 0; k < n; k++)
		begin
			sdi = (k < 32) ? tx[31-k] : 1'b0;
			#3;
			sclk  = 1'b1;
			rx[k] = sdo;
			#3;
			sclk = 1'b0;
		end
		#3;
		csN = 1'b1;
		sdi = ~sdi;
	endtask : xfer
endmodule : host_spi_model

// *** verif/adc_sample_fifo_status_crc_tb_top.sv ***
// Self-checking bench for the sample queue status, tag and CRC block
`timescale 1ns/1ps
module adc_sample_fifo_status_crc_tb_top;
	import adc_fifo_pkg::*;
	logic        clk, rst, sclk, csN, sdi, sdo, convValid, crcEnable, mainError, fifoIrq;
	logic [15:0] convData, perInputLimitCheckEnable;
	logic [3:0]  sourceIndex;
	logic [11:0] upperLimitValue, lowerLimitValue;
	int          errTotal, numChecks;

	adc_fifo_status DUT (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo),
		.convValid(convValid), .convData(convData), .sourceIndex(sourceIndex),
		.perInputLimitCheckEnable(perInputLimitCheckEnable), .upperLimitValue(upperLimitValue),
		.lowerLimitValue(lowerLimitValue), .crcEnable(crcEnable), .mainError(mainError),
		.fifoIrq(fifoIrq));
	host_spi_model HOST (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		numChecks++;
		if (got !== exp)
		begin
			errTotal++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	function automatic logic [23:0] fld(input logic [95:0] rx, input int lo, input int w);
		logic [23:0] v;
		v = '0;
		for (int i = 0; i < w; i++)
			v = {v[22:0], rx[lo+i]};
		return v;
	endfunction : fld

	function automatic logic [15:0] crc16(input logic [63:0] s);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 63; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ s[i]) ? 16'ha2eb : 16'h0000);
		return c;
	endfunction : crc16

	task automatic frame(input logic [31:0] tx, input int n, output logic [95:0] rx);
		HOST.xfer(tx, n, rx);
		repeat (8) @(posedge clk);
	endtask : frame

	task automatic wrctl(input logic [23:0] v);
		logic [95:0] rx;
		frame({8'h3a, v}, 32, rx);
	endtask : wrctl

	task automatic rdstat(input logic [7:0] exp);
		logic [95:0] rx;
		frame({8'h7b, 24'h000000}, 16, rx);
		chk(fld(rx, 8, 8), exp, "status");
	endtask : rdstat

	// One result from the converter; counts cycles with busy shown on the data-out line
	task automatic conv(input logic [15:0] d, input logic [3:0] s, output int hi);
		hi = 0;
		@(posedge clk);
		convValid   <= 1'b1;
		convData    <= d;
		sourceIndex <= s;
		@(posedge clk);
		convValid <= 1'b0;
		repeat (5)
		begin
			@(negedge clk);
			if (sdo === 1'b1)
				hi++;
		end
	endtask : conv

	task automatic t_reset;
		logic [95:0] rx;
		rdstat(8'h01);
		chk(fifoIrq, 1'b0, "irq after reset");
		frame({8'h7d, 8'h01, 16'h0000}, 40, rx);
		chk(fld(rx, 16, 24), 24'h000010, "empty read");
		rdstat(8'h01);
		$display("test reset done");
	endtask : t_reset

	task automatic t_watermark;
		logic [95:0] rx;
		int          hi;
		wrctl(24'h050202);
		chk(sdo, 1'b1, "ready when empty");
		conv(16'h9abc, 4'h3, hi);
		chk(sdo, 1'b1, "ready below mark");
		chk(fifoIrq, 1'b0, "irq below mark");
		conv(16'h1234, 4'h5, hi);
		chk(sdo, 1'b0, "ready at mark");
		chk(fifoIrq, 1'b1, "irq at mark");
		conv(16'h5555, 4'h5, hi);
		rdstat(8'h56);
		frame({8'h7d, 8'h02, 16'h0000}, 64, rx);
		chk(fld(rx, 16, 24), 24'h9abc43, "sample one");
		chk(fld(rx, 40, 24), 24'h123435, "sample two");
		chk(fifoIrq, 1'b0, "irq drained");
		@(posedge clk);
		mainError <= 1'b1;
		rdstat(8'h81);
		@(posedge clk);
		mainError <= 1'b0;
		$display("test watermark done");
	endtask : t_watermark

	task automatic t_stream_crc;
		logic [95:0] rx;
		logic [63:0] s;
		int          hi;
		s = {8'h7d, 8'h02, 16'h1111, 8'h01, 16'h2222, 8'h32};
		wrctl(24'h060202);
		conv(16'h1111, 4'h1, hi);
		chk(hi, 24'd1, "busy pulse");
		conv(16'h2222, 4'h2, hi);
		frame({8'h7d, 8'h02, 16'h0000}, 80, rx);
		chk(fld(rx, 16, 24), s[47:24], "stream one");
		chk(fld(rx, 40, 24), s[23:0], "stream two");
		chk(fld(rx, 64, 16), crc16(s), "crc word");
		$display("test stream crc done");
	endtask : t_stream_crc

	task automatic t_status_notag;
		logic [95:0] rx;
		int          hi;
		wrctl(24'h090202);
		conv(16'h7777, 4'h6, hi);
		wrctl(24'h090202);
		conv(16'h4444, 4'h4, hi);
		conv(16'h5566, 4'h4, hi);
		frame({8'h7d, 8'h02, 16'h0000}, 64, rx);
		chk(fld(rx, 8, 8), 8'h02, "appended status");
		chk(fld(rx, 16, 16), 16'h4444, "untagged one");
		chk(fld(rx, 32, 16), 16'h5566, "untagged two");
		chk(fld(rx, 48, 16), 16'h0000, "no crc");
		$display("test status append done");
	endtask : t_status_notag

	// Frame overlaps conversions: one write held, one lost, then a read refused
	task automatic t_collide;
		logic [95:0] rx, rs;
		int          hi, h2;
		wrctl(24'h050204);
		fork
			frame({8'h7b, 24'h000000}, 96, rs);
			begin
				repeat (3) @(posedge clk);
				conv(16'h1111, 4'h1, hi);
				conv(16'h2222, 4'h2, hi);
			end
		join
		rdstat(8'h40);
		@(negedge clk);
		fork
			frame({8'h7d, 8'h01, 16'h0000}, 40, rx);
			conv(16'h3333, 4'h3, h2);
		join
		chk(fld(rx, 16, 24), 24'h000000, "refused read");
		rdstat(8'h60);
		$display("test collide done");
	endtask : t_collide

	task automatic finish_test;
		$display("checks %0d errors %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	initial
	begin
		repeat (60000) @(posedge clk);
		errTotal++;
		$display("[ERR] %0t run timed out", $time);
		finish_test;
	end

	initial
	begin
		errTotal                 = 0;
		numChecks                = 0;
		rst                      = 1'b1;
		convValid                = 1'b0;
		convData                 = 16'h0000;
		sourceIndex              = 4'h0;
		perInputLimitCheckEnable = 16'h0008;
		upperLimitValue          = 12'h800;
		lowerLimitValue          = 12'h100;
		crcEnable                = 1'b1;
		mainError                = 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		t_reset;
		t_watermark;
		t_stream_crc;
		t_status_notag;
		t_collide;
		finish_test;
	end
endmodule : adc_sample_fifo_status_crc_tb_top
